// ==== logic/pastbl_top.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "pastbl_regs.svh"

// Behaviour
// R1: Each slot is a 4-bit field naming the ingress port served in it.
// R2: Code zero is the upstream port, codes one to five are ports one to five.
// R3: Codes six to fifteen are reserved and name no port.
// R4: A slot naming no valid requester is skipped with no time spent on it.
// R5: Software must not program reserved codes or the egress port's own code.
// R6: The word at 0x220 holds slots 0 to 7, slot 0 in the lowest nibble.
// R7: The word at 0x224 holds slots 8 to 15, slot 8 in the lowest nibble.
// R8: The word at 0x228 holds slots 16 to 23, slot 16 in the lowest nibble.
// R9: After reset slot n holds (n mod 7) plus one, and every slot is writable.
// R10: Writing one to the load command copies the table, writing zero does not.
// R11: The pending flag sets on any table write and clears when loading ends.
// R12: Loading works only in the upstream port; elsewhere pending reads zero.
// R13: The word at 0x22C holds slots 24 to 31 with the same layout and pattern.
// R14: Slots are visited in ascending order, one per period, wrapping to 0.

module pastbl_top
	import pastbl_pkg::*;
#(
	parameter int SLOTS = `PASTBL_SLOTS,
	parameter int NPORTS = `PASTBL_NPORTS,
	parameter int SW = $clog2(SLOTS),
	parameter int TW = SLOTS * `PASTBL_SLOT_W
) (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port role strap pin.
	input wire logic upstream_strap,
	// Arbitration side.
	input wire pastbl_port_t egress_port_id,
	input wire logic [NPORTS-1:0] port_req,
	input wire logic period_done,
	output logic grant_valid,
	output pastbl_port_t grant_port,
	output logic [SW-1:0] grant_slot
);

	localparam logic [11:0] TBL_BASE = `PASTBL_OFF_TBL0;

	// APB group.
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [11:0] addr_word;
	logic apb_setup;
	logic apb_wr;
	logic tbl_wr;
	logic ctrl_wr;
	logic [31:0] rd_data;
	logic rd_err;

	// Strap synchroniser.
	logic up_s1_r;
	logic up_s2_r;

	// Load and pending group.
	logic load_req_r;
	logic load_req_nxt;
	logic pending_r;
	logic pending_nxt;
	logic ld_now;

	// Arbiter group.
	pastbl_arb_state_t st_r;
	pastbl_arb_state_t st_nxt;
	logic [SW-1:0] ptr_r;
	logic [SW-1:0] ptr_nxt;
	logic gv_r;
	logic gv_nxt;
	pastbl_port_t gp_r;
	pastbl_port_t gp_nxt;

	// Tables and slot search.
	logic [TW-1:0] prog_tbl;
	logic [TW-1:0] act_tbl;
	logic pick_found;
	logic [SW-1:0] pick_idx;
	pastbl_port_t pick_port;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign grant_valid = gv_r;
	assign grant_port = gp_r;
	assign grant_slot = ptr_r;

	// The strap is caught through two flops after reset release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_s1_r <= 1'b0;
			up_s2_r <= 1'b0;
		end else if (clk_en) begin
			up_s1_r <= upstream_strap;
			up_s2_r <= up_s1_r;
		end
	end

	assign addr_word = {paddr[11:2], 2'b00};
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready_r;
	assign tbl_wr = apb_wr && addr_word[11:4] == TBL_BASE[11:4]; // R6 R13
	assign ctrl_wr = apb_wr && addr_word == `PASTBL_OFF_CTRL;

	// Read data and error are chosen in the setup cycle.
	always_comb begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		case (addr_word)
			`PASTBL_OFF_CTRL: begin
				rd_data[`PASTBL_LOAD_BIT] = load_req_r;
			end
			`PASTBL_OFF_STAT: begin
				rd_data[`PASTBL_PEND_BIT] = pending_r; // R11
			end
			`PASTBL_OFF_TBL0, `PASTBL_OFF_TBL1,
			`PASTBL_OFF_TBL2, `PASTBL_OFF_TBL3: begin
				rd_data = prog_tbl[{addr_word[3:2], 5'h00} +: 32]; // R7 R8
			end
			`PASTBL_OFF_ARBST: begin
				rd_data[`PASTBL_ARBST_PTR_LSB +: SW] = ptr_r;
				rd_data[`PASTBL_ARBST_GV_BIT] = gv_r;
				rd_data[`PASTBL_ARBST_GP_LSB +: `PASTBL_SLOT_W] = gp_r;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	always_comb begin
		pready_nxt = apb_setup;
		prdata_nxt = apb_setup ? rd_data : prdata_r;
		pslverr_nxt = apb_setup && rd_err;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (clk_en) begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Loading waits until no grant is in progress.
	assign ld_now = load_req_r && st_r == ARB_SEEK;

	always_comb begin
		load_req_nxt = load_req_r;
		pending_nxt = pending_r;
		if (ld_now) begin
			load_req_nxt = 1'b0;
			pending_nxt = 1'b0; // R11
		end
		if (ctrl_wr && pwdata[`PASTBL_LOAD_BIT] && up_s2_r) begin
			load_req_nxt = 1'b1; // R10 R12
		end
		if (tbl_wr) begin
			pending_nxt = 1'b1; // R11
		end
		if (!up_s2_r) begin
			load_req_nxt = 1'b0;
			pending_nxt = 1'b0; // R12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_req_r <= 1'b0;
			pending_r <= 1'b0;
		end else if (clk_en) begin
			load_req_r <= load_req_nxt;
			pending_r <= pending_nxt;
		end
	end

	pastbl_slot_store #(
		.SLOTS(SLOTS)
	) u_prog (
		.clk(pclk),
		.rst_n(presetn),
		.ce(clk_en),
		.we(tbl_wr),
		.widx(addr_word[3:2]),
		.wdata(pwdata),
		.ld(1'b0),
		.ld_data(act_tbl),
		.table_q(prog_tbl)
	);

	pastbl_slot_store #(
		.SLOTS(SLOTS)
	) u_act (
		.clk(pclk),
		.rst_n(presetn),
		.ce(clk_en),
		.we(1'b0),
		.widx(addr_word[3:2]),
		.wdata(pwdata),
		.ld(ld_now), // R10
		.ld_data(prog_tbl),
		.table_q(act_tbl)
	);

	pastbl_slot_pick #(
		.SLOTS(SLOTS),
		.NPORTS(NPORTS)
	) u_pick (
		.table_q(ld_now ? prog_tbl : act_tbl),
		.start(ptr_r),
		.req(port_req),
		.egress_id(egress_port_id),
		.found(pick_found),
		.idx(pick_idx),
		.port(pick_port)
	);

	// Slot walker: search, grant, then step to the next slot.
	always_comb begin
		st_nxt = st_r;
		ptr_nxt = ptr_r;
		gv_nxt = gv_r;
		gp_nxt = gp_r;
		case (st_r)
			ARB_SEEK: begin
				if (pick_found) begin
					st_nxt = ARB_GRANT;
					ptr_nxt = pick_idx; // R4
					gv_nxt = 1'b1;
					gp_nxt = pick_port; // R1
				end
			end
			ARB_GRANT: begin
				if (period_done) begin
					st_nxt = ARB_SEEK;
					ptr_nxt = ptr_r + SW'(1); // R14
					gv_nxt = 1'b0;
				end
			end
			default: begin
				st_nxt = ARB_SEEK;
				gv_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ARB_SEEK;
			ptr_r <= '0;
			gv_r <= 1'b0;
			gp_r <= `PASTBL_PORT_UP;
		end else if (clk_en) begin
			st_r <= st_nxt;
			ptr_r <= ptr_nxt;
			gv_r <= gv_nxt;
			gp_r <= gp_nxt;
		end
	end

	// Checks.
	pastbl_port_t act_at_ptr;
	assign act_at_ptr = act_tbl[{ptr_r, 2'b00} +: `PASTBL_SLOT_W];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	grant_from_table_a: assert property ( // R1
		gv_r |-> gp_r == act_at_ptr)
		else $error("Granted port differs from active slot.");

	grant_code_a: assert property ( // R3
		$rose(gv_r) |-> gp_r <= `PASTBL_PORT_MAX && gp_r != egress_port_id)
		else $error("Grant names reserved or egress port.");

	skip_free_a: assert property ( // R4
		st_r == ARB_SEEK && pick_found && clk_en |=> gv_r && ptr_r == $past(pick_idx))
		else $error("Usable slot not granted next cycle.");

	slot_step_a: assert property ( // R14
		gv_r && period_done && clk_en |=> !gv_r && ptr_r == $past(ptr_r) + SW'(1))
		else $error("Slot pointer did not step by one.");

	tbl_low_a: assert property ( // R6
		tbl_wr && clk_en && addr_word == `PASTBL_OFF_TBL0
		|=> prog_tbl[3:0] == $past(pwdata[3:0])
		&& prog_tbl[31:28] == $past(pwdata[31:28]))
		else $error("First table word layout wrong.");

	tbl_third_a: assert property ( // R8
		tbl_wr && clk_en && addr_word == `PASTBL_OFF_TBL2
		|=> prog_tbl[67:64] == $past(pwdata[3:0])
		&& prog_tbl[95:92] == $past(pwdata[31:28]))
		else $error("Third table word layout wrong.");

	pend_set_a: assert property ( // R11
		tbl_wr && clk_en && up_s2_r |=> pending_r [*2] or (pending_r ##1 1'b1))
		else $error("Pending flag not set by table write.");

	down_zero_a: assert property ( // R12
		!up_s2_r && clk_en |=> !pending_r && !load_req_r)
		else $error("Pending or load seen in downstream port.");

	load_done_a: assert property ( // R10
		ld_now && !tbl_wr && clk_en && up_s2_r
		|=> !pending_r && act_tbl == $past(prog_tbl)
		&& load_req_r == ($past(ctrl_wr)
		&& $past(pwdata[`PASTBL_LOAD_BIT])))
		else $error("Load did not copy table or clear pending.");

	grant_c: cover property (st_r == ARB_SEEK ##1 gv_r ##[1:8] !gv_r);
	skip_c: cover property (st_r == ARB_SEEK && pick_found && pick_idx != ptr_r);
	load_c: cover property (ld_now && up_s2_r);
	wrap_c: cover property (gv_r && period_done && ptr_r == '1);

endmodule

// ==== logic/pastbl_regs.svh ====
`ifndef PASTBL_REGS_SVH
`define PASTBL_REGS_SVH

// Register byte offsets on the APB bus.
`define PASTBL_OFF_CTRL 12'h214
`define PASTBL_OFF_STAT 12'h218
`define PASTBL_OFF_TBL0 12'h220
`define PASTBL_OFF_TBL1 12'h224
`define PASTBL_OFF_TBL2 12'h228
`define PASTBL_OFF_TBL3 12'h22C
`define PASTBL_OFF_ARBST 12'h230

// Field positions.
`define PASTBL_LOAD_BIT 16
`define PASTBL_PEND_BIT 16
`define PASTBL_ARBST_PTR_LSB 0
`define PASTBL_ARBST_GV_BIT 8
`define PASTBL_ARBST_GP_LSB 12

// Table shape.
`define PASTBL_SLOT_W 4
`define PASTBL_SLOTS 32
`define PASTBL_SLOTS_PER_REG 8
`define PASTBL_NPORTS 6

// Port identifier codes.
`define PASTBL_PORT_UP 4'h0
`define PASTBL_PORT_MAX 4'h5

// Reset pattern of the slots.
`define PASTBL_DFLT_CYCLE 7
`define PASTBL_DFLT_BASE 1

`endif

// ==== logic/pastbl_pkg.sv ====
package pastbl_pkg;

	typedef enum {
		ARB_SEEK,
		ARB_GRANT
	} pastbl_arb_state_t;

	typedef logic [3:0] pastbl_port_t;

endpackage

// ==== logic/pastbl_slot_store.sv ====
`timescale 1ns/1ps
`include "pastbl_regs.svh"

module pastbl_slot_store
	import pastbl_pkg::*;
#(
	parameter int SLOTS = `PASTBL_SLOTS,
	parameter int IW = $clog2(SLOTS / `PASTBL_SLOTS_PER_REG)
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Word write.
	input wire logic we,
	input wire logic [IW-1:0] widx,
	input wire logic [31:0] wdata,
	// Whole table load.
	input wire logic ld,
	input wire logic [SLOTS*`PASTBL_SLOT_W-1:0] ld_data,
	// Stored table.
	output logic [SLOTS*`PASTBL_SLOT_W-1:0] table_q
);

	for (genvar n = 0; n < SLOTS; n++) begin : g_slot
		pastbl_port_t slot_r;
		pastbl_port_t slot_nxt;

		always_comb begin
			slot_nxt = slot_r;
			if (ld) begin
				slot_nxt = ld_data[n*`PASTBL_SLOT_W +: `PASTBL_SLOT_W];
			end else if (we && widx == IW'(n / `PASTBL_SLOTS_PER_REG)) begin
				slot_nxt = wdata[(n % `PASTBL_SLOTS_PER_REG)*`PASTBL_SLOT_W
					+: `PASTBL_SLOT_W]; // R6 R7 R8 R13
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				slot_r <= 4'((n % `PASTBL_DFLT_CYCLE) + `PASTBL_DFLT_BASE); // R9
			end else if (ce) begin
				slot_r <= slot_nxt;
			end
		end

		assign table_q[n*`PASTBL_SLOT_W +: `PASTBL_SLOT_W] = slot_r; // R1
	end

endmodule

// ==== logic/pastbl_slot_pick.sv ====
`timescale 1ns/1ps
`include "pastbl_regs.svh"

module pastbl_slot_pick
	import pastbl_pkg::*;
#(
	parameter int SLOTS = `PASTBL_SLOTS,
	parameter int NPORTS = `PASTBL_NPORTS,
	parameter int SW = $clog2(SLOTS)
) (
	// Active table and search start.
	input wire logic [SLOTS*`PASTBL_SLOT_W-1:0] table_q,
	input wire logic [SW-1:0] start,
	// Requesters and own egress identifier.
	input wire logic [NPORTS-1:0] req,
	input wire pastbl_port_t egress_id,
	// First usable slot at or after start.
	output logic found,
	output logic [SW-1:0] idx,
	output pastbl_port_t port
);

	logic [SLOTS-1:0] usable;
	logic [15:0] req_ext;

	assign req_ext = 16'(req);

	// A slot is usable when its code names a real, requesting, foreign port.
	for (genvar n = 0; n < SLOTS; n++) begin : g_ok
		pastbl_port_t code;
		assign code = table_q[n*`PASTBL_SLOT_W +: `PASTBL_SLOT_W];
		assign usable[n] = (code <= `PASTBL_PORT_MAX) // R2 R3
			&& (code != egress_id) && req_ext[code]; // R4
	end

	// Unusable slots are passed over in the same cycle.
	always_comb begin
		logic [SW-1:0] j;
		j = start;
		found = 1'b0;
		idx = start;
		port = `PASTBL_PORT_UP;
		for (int k = 0; k < SLOTS; k++) begin
			j = start + SW'(k);
			if (!found && usable[j]) begin
				found = 1'b1; // R4 R14
				idx = j;
				port = table_q[{j, 2'b00} +: `PASTBL_SLOT_W];
			end
		end
	end

endmodule

// ==== tb/pastbl_ports_model.sv ====
`timescale 1ns/1ps

module pastbl_ports_model #(
	parameter int HOLD = 3
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Grant from the arbiter and wanted requests.
	input wire logic grant_valid,
	input wire logic [5:0] want,
	// Requests and end of period.
	output logic [5:0] port_req,
	output logic period_done
);
	int cnt;

	// Each grant is held for a fixed number of cycles, then ends.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			port_req <= 6'h00;
			period_done <= 1'b0;
		end else begin
			port_req <= want;
			cnt <= grant_valid ? cnt + 1 : 0;
			period_done <= grant_valid && cnt == HOLD - 1;
		end
	end
endmodule

// ==== tb/pastbl_top_tb.sv ====
`timescale 1ns/1ps
`include "pastbl_regs.svh"

module pastbl_top_tb
	import pastbl_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, strap, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e, gv, pd, prev_gv, ce;
	logic [5:0] want, req, req_d;
	pastbl_port_t egr, egr_d, gp;
	logic [4:0] gs;
	logic [127:0] act;
	int failures, cmp_count, ptr, gcnt, s;

	pastbl_top i_pastbl_top (.pclk(pclk), .presetn(presetn),
		.clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .upstream_strap(strap), .egress_port_id(egr),
		.port_req(req), .period_done(pd), .grant_valid(gv),
		.grant_port(gp), .grant_slot(gs));
	pastbl_ports_model i_pastbl_ports_model (.pclk(pclk),
		.presetn(presetn), .grant_valid(gv), .want(want),
		.port_req(req), .period_done(pd));

	function automatic logic [31:0] dflt(int w);
		logic [31:0] v;
		for (int j = 0; j < 8; j++) begin
			v[4*j+:4] = 4'((8 * w + j) % 7 + 1);
		end
		return v;
	endfunction

	function automatic int pick(int p);
		int k;
		logic [3:0] c;
		for (int i = 0; i < 32; i++) begin
			k = (p + i) % 32;
			c = act[4*k+:4];
			if (c <= 4'h5 && c != egr_d && req_d[c]) begin
				return k;
			end
		end
		return p;
	endfunction

	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic grants(int n);
		int t;
		t = gcnt + n;
		while (gcnt < t) @(posedge pclk);
		want <= 6'h00;
		repeat (10) @(posedge pclk);
	endtask

	task automatic close_out();
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Grant monitor: slot order and port decode from a table model.
	always @(posedge pclk) begin
		req_d <= req;
		egr_d <= egr;
		prev_gv <= gv;
		if (presetn && gv === 1'b1 && prev_gv === 1'b0) begin
			s = pick(ptr);
			chk("grant_slot", 32'(s), 32'(gs));
			chk("grant_port", 32'(act[4*s+:4]), 32'(gp));
			ptr = (s + 1) % 32;
			gcnt++;
		end
	end

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	initial begin
		#2000000;
		failures++;
		close_out();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{want, egr} = '0;
		ce = 1'b1;
		strap = 1'b1;
		act = {dflt(3), dflt(2), dflt(1), dflt(0)};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		for (int w = 0; w < 4; w++) begin
			apb(1'b0, 12'h220 + 12'(4 * w), 32'h0);
			chk("table reset", dflt(w), q);
		end
		apb(1'b0, 12'h200, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, q);
		want <= 6'h3E;
		grants(26);
		egr <= 4'h4;
		apb(1'b1, 12'h220, 32'h0520_1305);
		apb(1'b1, 12'h224, 32'h2135_0123);
		apb(1'b1, 12'h228, 32'h0011_2233);
		apb(1'b0, 12'h220, 32'h0);
		chk("table word 0", 32'h0520_1305, q);
		apb(1'b0, 12'h224, 32'h0);
		chk("table word 1", 32'h2135_0123, q);
		apb(1'b0, 12'h228, 32'h0);
		chk("table word 2", 32'h0011_2233, q);
		ce <= 1'b0;
		strap <= 1'b0;
		repeat (6) @(posedge pclk);
		ce <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b1, 12'h214, 32'h0);
		apb(1'b0, 12'h218, 32'h0);
		chk("pending", 32'h0001_0000, q);
		apb(1'b1, 12'h214, 32'h0001_0000);
		act[95:0] = {32'h0011_2233, 32'h2135_0123, 32'h0520_1305};
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h218, 32'h0);
		chk("pending", 32'h0, q);
		want <= 6'h3F;
		grants(20);
		apb(1'b0, 12'h230, 32'h0);
		chk("arb status", (32'(act[4*((ptr+31)%32)+:4]) << 12)
			| 32'(ptr), q);
		strap <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b1, 12'h220, 32'h1111_1111);
		apb(1'b0, 12'h218, 32'h0);
		chk("downstream pending", 32'h0, q);
		apb(1'b1, 12'h214, 32'h0001_0000);
		apb(1'b0, 12'h214, 32'h0);
		chk("downstream load", 32'h0, q);
		close_out();
	end
endmodule
